// file: core/erout_top.sv
// event router control: registers, lanes, consumer muxes, interrupt
// Contract
// - overrun and detected source per channel
// - flag set when its condition occurs
// - enable-set ones enable sources
// - enable-clear ones disable; both read mask
// - request while flag and enable set
// - all sources ORed into one request
// - overrun on event when busy or unready
// - overrun only on resync lanes
// - detected flag on each resync lane event
// - detected flag only on resync lanes
// - interrupt is wake source without clock
// - clock requested during event, then dropped
// - async lanes never request a clock
// - soft reset clears registers and events
// - byte, halfword and word accesses work
// - bit four keeps lane clocks on
// - soft reset bit zero; zero ignored
// - soft reset discards rest of write
// - path codes sync, resync, async, reserved
// - status shows lane pending and consumers ready
`timescale 1ns/1ps
`default_nettype none
module erout_top #(
  parameter int NGEN = erout_pkg::NGEN_DEF,
  parameter int NUSER = erout_pkg::NUSER_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [erout_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NGEN-1:0] gen_in,
  input wire logic [NUSER-1:0] user_ready,
  input wire logic [NUSER-1:0] user_ack,
  output logic [NUSER-1:0] user_event,
  output logic [erout_pkg::NCH-1:0] lane_clk_req,
  output logic irq_req
);
  import erout_pkg::*;

  // ***********************************************************
  // parameter checks
  // ***********************************************************
  if (NGEN < 2 || NGEN > 128) begin : g_bad_ngen
    $error("NGEN must lie between 2 and 128");
  end
  if (NUSER < 1 || NUSER > 32) begin : g_bad_nuser
    $error("NUSER must lie between 1 and 32");
  end

  // ***********************************************************
  // helpers
  // ***********************************************************
  // shared word layout
  function automatic logic [31:0] pack_word(input logic [NCH-1:0] lo,
                                            input logic [NCH-1:0] hi);
    pack_word = {4'h0, hi[11:8], 4'h0, lo[11:8], hi[7:0], lo[7:0]};
  endfunction : pack_word

  function automatic logic [NCH-1:0] low_of(input logic [31:0] w);
    low_of = {w[19:16], w[7:0]};
  endfunction : low_of

  function automatic logic [NCH-1:0] high_of(input logic [31:0] w);
    high_of = {w[27:24], w[15:8]};
  endfunction : high_of

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // ***********************************************************
  // declarations
  // ***********************************************************
  logic rst_all;
  logic srst_reg;
  logic keep_on_reg;
  logic [3:0] route_sel_reg;
  logic [GEN_W-1:0] gen_sel_reg [NCH];
  erout_path_type path_reg [NCH];
  erout_edge_type edge_reg [NCH];
  logic [NCH-1:0] sw_evt_reg;
  logic [USEL_W-1:0] cons_sel_reg;
  logic [USEL_W-1:0] user_chan_reg [NUSER];
  logic [NUSER-1:0] pend_reg;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic wr_ok;
  logic srst_hit;
  logic [3:0] route_tgt;
  logic [USEL_W-1:0] cons_tgt;
  logic [NCH-1:0] lane_evt;
  logic [NCH-1:0] lane_busy;
  logic [NCH-1:0] lane_ovr;
  logic [NCH-1:0] lane_det;
  logic [NCH-1:0] lane_req;
  logic [NCH-1:0] lane_live;
  logic [NCH-1:0] ready_all;
  logic [NCH-1:0] done_all;
  logic [NCH-1:0] gen_pick;
  logic [NUSER-1:0] user_hit;
  logic [NUSER-1:0] user_sync;
  logic [31:0] set_vec;
  logic [31:0] flag_clr;
  logic [31:0] en_set;
  logic [31:0] en_clr;
  logic [31:0] flags;
  logic [31:0] enables;
  logic bank_irq;
  logic [31:0] rdata_next;

  // ***********************************************************
  // write decode and soft reset
  // ***********************************************************
  always_comb begin
    wmask = lane_mask(reg_be);
    wbits = reg_wdata & wmask;
    // a one in bit zero resets
    srst_hit = reg_wr && reg_addr == OFF_CTRL && wbits[CTRL_SRST_BIT];
    wr_ok = reg_wr && !srst_hit;
    route_tgt = reg_be[0] ? reg_wdata[RC_SEL_LSB +: 4] : route_sel_reg;
    cons_tgt = reg_be[0] ? reg_wdata[CS_USER_LSB +: USEL_W] : cons_sel_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= srst_hit;
    end
  end

  assign rst_all = sys_rst | srst_reg;

  // ***********************************************************
  // control and lane configuration
  // ***********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      keep_on_reg <= 1'b0;
    end else if (wr_ok && reg_addr == OFF_CTRL && reg_be[0]) begin
      keep_on_reg <= reg_wdata[CTRL_KEEP_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      route_sel_reg <= 4'h0;
      sw_evt_reg <= '0;
      for (int c = 0; c < NCH; c++) begin
        gen_sel_reg[c] <= 7'h00;
        path_reg[c] <= PATH_SYNC;
        edge_reg[c] <= EDGE_NONE;
      end
    end else begin
      sw_evt_reg <= '0;
      if (wr_ok && reg_addr == OFF_ROUTE) begin
        if (reg_be[0]) begin
          route_sel_reg <= route_tgt;
        end
        for (int c = 0; c < NCH; c++) begin
          if (route_tgt == 4'(c)) begin
            if (reg_be[1]) begin
              sw_evt_reg[c] <= reg_wdata[RC_SWEVT_BIT];
            end
            if (reg_be[2]) begin
              gen_sel_reg[c] <= reg_wdata[RC_GEN_LSB +: GEN_W];
            end
            if (reg_be[3]) begin
              path_reg[c] <= erout_path_type'(reg_wdata[RC_PATH_LSB +: 2]);
              edge_reg[c] <= erout_edge_type'(reg_wdata[RC_EDGE_LSB +: 2]);
            end
          end
        end
      end
    end
  end

  // ***********************************************************
  // consumer multiplexers
  // ***********************************************************
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      cons_sel_reg <= 5'h00;
      for (int u = 0; u < NUSER; u++) begin
        user_chan_reg[u] <= 5'h00;
      end
    end else if (wr_ok && reg_addr == OFF_CONS) begin
      if (reg_be[0]) begin
        cons_sel_reg <= cons_tgt;
      end
      for (int u = 0; u < NUSER; u++) begin
        if (reg_be[1] && cons_tgt == 5'(u)) begin
          user_chan_reg[u] <= reg_wdata[CS_CHAN_LSB +: USEL_W];
        end
      end
    end
  end

  // channel code 0 means unconnected, code n+1 means lane n
  always_comb begin
    ready_all = '1;
    done_all = '1;
    user_hit = '0;
    user_sync = '0;
    for (int u = 0; u < NUSER; u++) begin
      for (int c = 0; c < NCH; c++) begin
        if (user_chan_reg[u] == 5'(c + 1)) begin
          ready_all[c] = ready_all[c] & user_ready[u];
          done_all[c] = done_all[c] & ~pend_reg[u];
          user_hit[u] = lane_evt[c];
          user_sync[u] = lane_live[c];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      user_event <= '0;
      pend_reg <= '0;
    end else begin
      user_event <= user_hit;
      pend_reg <= (pend_reg & ~user_ack) | (user_hit & user_sync);
    end
  end

  // ***********************************************************
  // lanes
  // ***********************************************************
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      lane_live[c] = (path_reg[c] != PATH_ASYNC);
      gen_pick[c] = 1'b0;
      for (int g = 1; g < NGEN; g++) begin
        if (gen_sel_reg[c] == 7'(g)) begin
          gen_pick[c] = gen_in[g];
        end
      end
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_lane
    erout_lane u_lane (
      .sys_clk(sys_clk),
      .rst(rst_all),
      .path(path_reg[c]),
      .edge_sel(edge_reg[c]),
      .gen_in(gen_pick[c]),
      .sw_evt(sw_evt_reg[c]),
      .keep_on(keep_on_reg),
      .ready_all(ready_all[c]),
      .done_all(done_all[c]),
      .evt(lane_evt[c]),
      .busy(lane_busy[c]),
      .ovr_set(lane_ovr[c]),
      .det_set(lane_det[c]),
      .clk_req(lane_req[c])
    );
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      lane_clk_req <= '0;
    end else begin
      lane_clk_req <= lane_req & lane_live;
    end
  end

  // ***********************************************************
  // flags, enables and request
  // ***********************************************************
  always_comb begin
    set_vec = pack_word(lane_ovr, lane_det);
    flag_clr = '0;
    en_set = '0;
    en_clr = '0;
    if (wr_ok && reg_addr == OFF_FLAGS) begin
      flag_clr = wbits;
    end
    if (wr_ok && reg_addr == OFF_EN_SET) begin
      en_set = wbits;
    end
    if (wr_ok && reg_addr == OFF_EN_CLR) begin
      en_clr = wbits;
    end
  end

  erout_bank #(
    .W(32)
  ) u_bank (
    .sys_clk(sys_clk),
    .rst(rst_all),
    .set_vec(set_vec),
    .clr_vec(flag_clr),
    .en_set(en_set),
    .en_clr(en_clr),
    .flags(flags),
    .enables(enables),
    .irq(bank_irq)
  );

  // level request needs no lane clock to hold, so it can wake the core
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= bank_irq;
    end
  end

  // ***********************************************************
  // read port
  // ***********************************************************
  always_comb begin
    rdata_next = RST_WORD;
    case (reg_addr)
      OFF_CTRL: rdata_next[CTRL_KEEP_BIT] = keep_on_reg;
      OFF_ROUTE: begin
        rdata_next[RC_SEL_LSB +: 4] = route_sel_reg;
        for (int c = 0; c < NCH; c++) begin
          if (route_sel_reg == 4'(c)) begin
            rdata_next[RC_GEN_LSB +: GEN_W] = gen_sel_reg[c];
            rdata_next[RC_PATH_LSB +: 2] = path_reg[c];
            rdata_next[RC_EDGE_LSB +: 2] = edge_reg[c];
          end
        end
      end
      OFF_CONS: begin
        rdata_next[CS_USER_LSB +: USEL_W] = cons_sel_reg;
        for (int u = 0; u < NUSER; u++) begin
          if (cons_sel_reg == 5'(u)) begin
            rdata_next[CS_CHAN_LSB +: USEL_W] = user_chan_reg[u];
          end
        end
      end
      OFF_STATUS: rdata_next = pack_word(ready_all & lane_live, lane_busy & lane_live);
      // both enable words read the mask
      OFF_EN_CLR: rdata_next = enables;
      OFF_EN_SET: rdata_next = enables;
      OFF_FLAGS: begin
        rdata_next = flags & pack_word(lane_live, lane_live);
      end
      default: rdata_next = RST_WORD;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      reg_rdata <= RST_WORD;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= RST_WORD;
    end
  end

  wire unused_ok = &{1'b0, high_of(flags), low_of(flags)};
endmodule : erout_top
`default_nettype wire

// file: core/erout_pkg.sv
// constants and types shared by the event router files
package erout_pkg;
  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int NCH = 12;
  localparam int ADDR_W = 5;
  localparam int NGEN_DEF = 128;
  localparam int NUSER_DEF = 16;
  localparam int GEN_W = 7;
  localparam int USEL_W = 5;
  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_ROUTE = 5'h04;
  localparam logic [4:0] OFF_CONS = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_EN_CLR = 5'h10;
  localparam logic [4:0] OFF_EN_SET = 5'h14;
  localparam logic [4:0] OFF_FLAGS = 5'h18;
  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int CTRL_KEEP_BIT = 4;
  localparam int CTRL_SRST_BIT = 0;
  localparam int RC_SEL_LSB = 0;
  localparam int RC_SWEVT_BIT = 8;
  localparam int RC_GEN_LSB = 16;
  localparam int RC_PATH_LSB = 24;
  localparam int RC_EDGE_LSB = 26;
  localparam int CS_USER_LSB = 0;
  localparam int CS_CHAN_LSB = 8;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ***********************************************************
  // encodings
  // ***********************************************************
  typedef enum logic [1:0] {
    PATH_SYNC = 2'h0,
    PATH_RESYNC = 2'h1,
    PATH_ASYNC = 2'h2,
    PATH_RSVD = 2'h3
  } erout_path_type;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } erout_edge_type;
  typedef enum logic [1:0] {
    LS_IDLE = 2'b01,
    LS_BUSY = 2'b10
  } erout_lane_state_type;
endpackage : erout_pkg

// file: core/erout_lane.sv
// one event lane: resync, edge detect, busy tracking, clock request
`timescale 1ns/1ps
`default_nettype none
module erout_lane (
  input wire logic sys_clk,
  input wire logic rst,
  input wire erout_pkg::erout_path_type path,
  input wire erout_pkg::erout_edge_type edge_sel,
  input wire logic gen_in,
  input wire logic sw_evt,
  input wire logic keep_on,
  input wire logic ready_all,
  input wire logic done_all,
  output logic evt,
  output logic busy,
  output logic ovr_set,
  output logic det_set,
  output logic clk_req
);
  import erout_pkg::*;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic is_async;
  logic is_resync;
  logic lvl;
  logic edge_hit;
  logic hit;
  erout_lane_state_type state_reg;
  erout_lane_state_type state_next;

  always_comb begin
    is_async = (path == PATH_ASYNC);
    is_resync = (path == PATH_RESYNC);
    lvl = is_resync ? sync2_reg : gen_in;
    case (edge_sel)
      EDGE_RISE: edge_hit = lvl & ~prev_reg;
      EDGE_FALL: edge_hit = ~lvl & prev_reg;
      EDGE_BOTH: edge_hit = lvl ^ prev_reg;
      default: edge_hit = 1'b0;
    endcase
    hit = (edge_hit | sw_evt) & ~is_async;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= gen_in;
      sync2_reg <= sync1_reg;
      prev_reg <= lvl;
    end
  end

  // stay busy while the pulse is still on its way to the consumers
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LS_IDLE: begin
        if (hit) begin
          state_next = LS_BUSY;
        end
      end
      LS_BUSY: begin
        if (!hit && !evt && done_all) begin
          state_next = LS_IDLE;
        end
      end
      default: state_next = LS_IDLE;
    endcase
    if (is_async) begin
      state_next = LS_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= LS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg == LS_BUSY);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      evt <= 1'b0;
      ovr_set <= 1'b0;
      det_set <= 1'b0;
      clk_req <= 1'b0;
    end else begin
      evt <= is_async ? gen_in : hit;
      ovr_set <= hit & is_resync & (~ready_all | busy);
      det_set <= hit & is_resync;
      clk_req <= ~is_async & (keep_on | (gen_in ^ prev_reg) | hit | busy);
    end
  end
endmodule : erout_lane
`default_nettype wire

// file: core/erout_bank.sv
// sticky flag bank with enable mask and one combined request
`timescale 1ns/1ps
`default_nettype none
module erout_bank #(
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] set_vec,
  input wire logic [W-1:0] clr_vec,
  input wire logic [W-1:0] en_set,
  input wire logic [W-1:0] en_clr,
  output logic [W-1:0] flags,
  output logic [W-1:0] enables,
  output logic irq
);
  logic [W-1:0] flags_next;
  logic [W-1:0] en_next;

  always_comb begin
    flags_next = (flags & ~clr_vec) | set_vec;
    en_next = (enables | en_set) & ~en_clr;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags <= '0;
      enables <= '0;
      irq <= 1'b0;
    end else begin
      flags <= flags_next;
      enables <= en_next;
      irq <= |(flags_next & en_next);
    end
  end
endmodule : erout_bank
`default_nettype wire

// file: dv/erout_top_monitor.sv
// assertion checker on the event router control ports
`timescale 1ns/1ps
`default_nettype none
module erout_top_monitor #(
  parameter int NUSER = erout_pkg::NUSER_DEF
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [erout_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [3:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUSER-1:0] user_event,
  input wire logic [erout_pkg::NCH-1:0] lane_clk_req,
  input wire logic irq_req
);
  import erout_pkg::*;
  // ***********************************************************
  // port relations
  // ***********************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside its cycle");
  AST_UNMAPPED: assert property (reg_rd && (reg_addr > OFF_FLAGS || reg_addr[1:0] != 2'h0)
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  AST_CTRL_READ: assert property (reg_rd && reg_addr == OFF_CTRL
    |=> reg_rdata[0] == 1'b0 && reg_rdata[31:8] == 24'h0) else $error("control read bad");
  AST_EN_SAME: assert property ((reg_rd && reg_addr == OFF_EN_SET) ##1
    (reg_rd && reg_addr == OFF_EN_CLR) |=> reg_rdata == $past(reg_rdata))
    else $error("enable views differ");
  AST_EN_ZERO_QUIET: assert property ((reg_rd && reg_addr == OFF_EN_SET) ##1
    reg_rdata == 32'h0 |-> !irq_req) else $error("request with no enables");
  AST_FLAGS_ZERO_QUIET: assert property ((reg_rd && reg_addr == OFF_FLAGS) ##1
    reg_rdata == 32'h0 |-> !irq_req) else $error("request with no flags");
  AST_ENCLR_DROPS: assert property (reg_wr && reg_addr == OFF_EN_CLR && reg_be == 4'hF
    && reg_wdata == 32'hFFFF_FFFF |-> ##2 !irq_req) else $error("request kept after disable");
  AST_SRST_CLEARS: assert property (reg_wr && reg_addr == OFF_CTRL && reg_be[0] &&
    reg_wdata[0] |-> ##3 (!irq_req && lane_clk_req == '0 && user_event == '0))
    else $error("soft reset left outputs active");
  AST_IRQ_HOLD: assert property ($fell(irq_req) |-> $past(reg_wr) || $past(reg_wr, 2) ||
    $past(reg_wr, 3) || $past(sys_rst)) else $error("request dropped without cause");
  AST_RESET_QUIET: assert property (disable iff (1'b0) $past(sys_rst)
    |-> (!irq_req && lane_clk_req == '0 && user_event == '0)) else $error("outputs live in reset");
endmodule : erout_top_monitor
bind erout_top erout_top_monitor #(.NUSER(NUSER)) u_monitor (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .user_event(user_event),
  .lane_clk_req(lane_clk_req), .irq_req(irq_req));
`default_nettype wire

// file: dv/erout_consumers.sv
// consumer peripherals that answer routed events, promptly or held off
`timescale 1ns/1ps
`default_nettype none
module erout_consumers #(
  parameter int NUSER = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic [NUSER-1:0] user_event,
  output logic [NUSER-1:0] user_ready,
  output logic [NUSER-1:0] user_ack
);
  logic [NUSER-1:0] owed_reg;
  // held-off consumers report not ready
  assign user_ready = {NUSER{~stall}};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      owed_reg <= '0;
      user_ack <= '0;
    end else begin
      // events seen while held off are answered on release
      user_ack <= stall ? '0 : (owed_reg | user_event);
      owed_reg <= stall ? (owed_reg | user_event) : '0;
    end
  end
endmodule : erout_consumers
`default_nettype wire

// file: dv/tb_erout_top.sv
// self-checking bench for the event router control block
`timescale 1ns/1ps
`default_nettype none
module tb_erout_top;
  import erout_pkg::*;
  localparam int NG = 8;
  localparam int NU = 4;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic sys_clk, sys_rst, reg_wr, reg_rd, stall, irq_req;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] reg_be;
  logic [NG-1:0] gen_in;
  logic [NU-1:0] user_ready, user_ack, user_event;
  logic [NCH-1:0] lane_clk_req;
  int bad_count, n_checks;
  erout_top #(.NGEN(NG), .NUSER(NU)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_in(gen_in), .user_ready(user_ready),
    .user_ack(user_ack), .user_event(user_event), .lane_clk_req(lane_clk_req), .irq_req(irq_req));
  erout_consumers #(.NUSER(NU)) u_cons (.sys_clk(sys_clk), .sys_rst(sys_rst), .stall(stall),
    .user_event(user_event), .user_ready(user_ready), .user_ack(user_ack));
  // ***********************************************************
  // bus and compare tasks
  // ***********************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= be;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] want);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, want);
    @(posedge sys_clk);
  endtask : rd
  task automatic wait_ev(input int u);
    int k;
    k = 0;
    while (user_event[u] !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk({31'h0, user_event[u]}, 32'h1);
    @(posedge sys_clk);
  endtask : wait_ev
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // generous bound: the sequence needs about 120 cycles of the 4000
  initial begin
    #(4000 * 25);
    bad_count++;
    close_out();
  end
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, stall} = 3'h0;
    reg_addr = '0;
    reg_wdata = 32'h0;
    reg_be = 4'h0;
    gen_in = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(OFF_CTRL, ALL, 32'h0);
    rd(OFF_EN_SET, ALL, 32'h0);
    rd(OFF_FLAGS, ALL, 32'h0);
    wr(5'h1C, ALL, 4'hF);
    rd(5'h1C, ALL, 32'h0);
    // only byte lane one may land
    wr(OFF_EN_SET, ALL, 4'h2);
    wr(OFF_EN_SET, 32'h0, 4'hF);
    reg_addr <= OFF_EN_SET;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_addr <= OFF_EN_CLR;
    #1 chk(reg_rdata, 32'h0000_FF00);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 32'h0000_FF00);
    @(posedge sys_clk);
    wr(OFF_EN_CLR, 32'h0000_FE00, 4'hF);
    rd(OFF_EN_SET, ALL, 32'h0000_0100);
    // user0 on lane0 resync rising gen1, user1 on lane1 async gen2
    wr(OFF_CONS, 32'h0000_0100, 4'h3);
    wr(OFF_CONS, 32'h0000_0201, 4'h3);
    wr(OFF_ROUTE, 32'h0501_0000, 4'hF);
    wr(OFF_ROUTE, 32'h0202_0001, 4'hF);
    gen_in[1] <= 1'b1;
    wait_ev(0);
    repeat (2) @(posedge sys_clk);
    rd(OFF_FLAGS, ALL, 32'h0000_0100);
    rd(OFF_STATUS, 32'h0000_0101, 32'h0000_0001);
    wr(OFF_FLAGS, 32'h0, 4'hF);
    @(negedge sys_clk) chk({31'h0, irq_req}, 32'h1);
    @(posedge sys_clk) wr(OFF_EN_CLR, ALL, 4'hF);
    @(negedge sys_clk) chk({31'h0, irq_req}, 32'h0);
    @(posedge sys_clk) wr(OFF_EN_SET, 32'h0000_0100, 4'hF);
    @(negedge sys_clk) chk({31'h0, irq_req}, 32'h1);
    @(posedge sys_clk) wr(OFF_FLAGS, 32'h0000_0100, 4'hF);
    @(negedge sys_clk) chk({31'h0, irq_req}, 32'h0);
    @(posedge sys_clk) rd(OFF_FLAGS, ALL, 32'h0);
    // consumer held off: event while not ready overruns
    gen_in[1] <= 1'b0;
    stall <= 1'b1;
    repeat (6) @(posedge sys_clk);
    gen_in[1] <= 1'b1;
    wait_ev(0);
    repeat (2) @(posedge sys_clk);
    rd(OFF_FLAGS, ALL, 32'h0000_0101);
    rd(OFF_STATUS, 32'h0000_0101, 32'h0000_0100);
    @(negedge sys_clk) chk({31'h0, lane_clk_req[0]}, 32'h1);
    @(posedge sys_clk) stall <= 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk) chk({31'h0, lane_clk_req[0]}, 32'h0);
    @(posedge sys_clk) rd(OFF_STATUS, 32'h0000_0101, 32'h0000_0001);
    wr(OFF_FLAGS, ALL, 4'hF);
    gen_in[2] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) chk({28'h0, user_event}, 32'h2);
    chk({20'h0, lane_clk_req}, 32'h0);
    @(posedge sys_clk) gen_in[2] <= 1'b0;
    rd(OFF_FLAGS, ALL, 32'h0);
    rd(OFF_STATUS, 32'h0000_0202, 32'h0);
    // software event on lane zero must flag like a generator edge
    wr(OFF_ROUTE, 32'h0501_0100, 4'hF);
    repeat (2) @(posedge sys_clk);
    rd(OFF_FLAGS, ALL, 32'h0000_0100);
    wr(OFF_CTRL, 32'h10, 4'h1);
    wr(OFF_CTRL, 32'h0, 4'h2);
    rd(OFF_CTRL, ALL, 32'h10);
    @(negedge sys_clk) chk({20'h0, lane_clk_req}, 32'hFFD);
    // generators quiet before the soft reset
    @(posedge sys_clk) gen_in <= '0;
    wr(OFF_CTRL, 32'h11, 4'h1);
    @(posedge sys_clk);
    rd(OFF_CTRL, ALL, 32'h0);
    rd(OFF_EN_SET, ALL, 32'h0);
    @(negedge sys_clk) chk({20'h0, lane_clk_req}, 32'h0);
    close_out();
  end
endmodule : tb_erout_top
`default_nettype wire
